// ### logic/clock_control_pkg.sv
// constants and types shared by the clock control block and its leaves
// assumes a single 100 MHz reference clock and a 32-bit avalon-mm host
`default_nettype none
package clock_control_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // start-up timing, times in their own unit, counts derived (rounded up)
  localparam int BOOT_BASE_CK = 14;
  localparam int WAKE_CK = 6;
  localparam int FAST_RISE_TIME_NS = 4100000;
  localparam int SLOW_RISE_TIME_NS = 65000000;
  localparam int FAST_RISE_CYCLES =
    (FAST_RISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_RISE_CYCLES =
    (SLOW_RISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CNT_W = 24;
  // start-up field encodings
  localparam logic [1:0] STARTUP_BOD = 2'h0;
  localparam logic [1:0] STARTUP_FAST = 2'h1;
  localparam logic [1:0] STARTUP_SLOW = 2'h2;
  // prescaler
  localparam int DIV_SEL_W = 4;
  localparam int DIV_CNT_W = 8;
  localparam logic [3:0] DIV_SEL_DEFAULT = 4'h0;
  localparam logic [3:0] DIV_SEL_MAX = 4'h8;
  // register byte offsets
  localparam logic [3:0] ADDR_DIVISION = 4'h0;
  localparam logic [3:0] ADDR_TIMER_STATUS = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // field positions
  localparam int TMR_ENABLE_BIT = 0;
  localparam int TMR_EXT_CLK_BIT = 1;
  localparam int TMR_ACTIVE_BIT = 2;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_DIV_LSB = 4;
  localparam int ST_INBUF_BIT = 8;
  localparam int ST_FIELD_LSB = 9;
  // sleep modes
  localparam logic [1:0] SLEEP_IDLE = 2'h0;
  localparam logic [1:0] SLEEP_ADC_QUIET = 2'h1;
  localparam logic [1:0] SLEEP_DEEP = 2'h2;
  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN = 2'h1,
    ST_SLEEP = 2'h3,
    ST_WAKE = 2'h2
  } clk_state_type;
endpackage : clock_control_pkg
`default_nettype wire

// ### logic/pin_synchronizer.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes the input is asynchronous to ref_clk
`default_nettype none
module pin_synchronizer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
  wire agree = (s2_reg == s3_reg);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
      rise_reg <= agree && s3_reg && !level_reg;
    end
  end
  assign level = level_reg;
  assign rise = rise_reg;
endmodule : pin_synchronizer
`default_nettype wire

// ### logic/clock_divider.sv
// power-of-two prescaler producing a tick enable and a square divided clock
// assumes sel_req is stable between ticks of the reference domain
`default_nettype none
module clock_divider #(
  parameter int SEL_W = clock_control_pkg::DIV_SEL_W,
  parameter int CNT_W = clock_control_pkg::DIV_CNT_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [SEL_W-1:0] sel_req,
  output logic tick,
  output logic div_clk,
  output logic [SEL_W-1:0] active_sel
);
  import clock_control_pkg::*;
  function automatic logic [CNT_W:0] period_of(input logic [SEL_W-1:0] s);
    period_of = (CNT_W+1)'(1) << s;
  endfunction : period_of
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [SEL_W-1:0] sel_reg;
  logic div_clk_reg, div_clk_next;
  logic [CNT_W-1:0] gap_reg;
  wire [CNT_W:0] period = period_of(sel_reg);
  wire [CNT_W:0] cnt_wide = {1'b0, cnt_reg};
  wire last = (cnt_wide == period - (CNT_W+1)'(1));
  wire fall_point = (cnt_wide + (CNT_W+1)'(1) == (period >> 1));
  // new setting only taken at a period boundary: no runt, no fast period
  assign cnt_next = last ? '0 : cnt_reg + CNT_W'(1);
  assign div_clk_next = last ? 1'b1 : (fall_point ? 1'b0 : div_clk_reg);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      sel_reg <= DIV_SEL_DEFAULT;
      div_clk_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      div_clk_reg <= div_clk_next;
      if (last) begin
        sel_reg <= sel_req;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= tick ? '0 : gap_reg + CNT_W'(1);
    end
  end
  assign tick = last;
  assign div_clk = div_clk_reg;
  assign active_sel = sel_reg;
  property p_period_len;
    @(posedge ref_clk) disable iff (!nrst)
    tick |-> ({1'b0, gap_reg} + (CNT_W+1)'(1) == period);
  endproperty
  a_period_len: assert property (p_period_len)
    else $error("divided period differs from its active setting");
  property p_high_after_tick;
    @(posedge ref_clk) disable iff (!nrst)
    (tick && period > (CNT_W+1)'(1)) |=> div_clk ##1 ($past(div_clk) == 1'b1);
  endproperty
  a_high_after_tick: assert property (p_high_after_tick)
    else $error("divided clock not high at start of period");
endmodule : clock_divider
`default_nettype wire

// ### logic/system_clock_startup_prescaler.sv
// system clock control: start-up delay, prescaler, clock out, timer osc
// assumes an avalon-mm host on ref_clk and fuse-like straps held steady
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`default_nettype none
module system_clock_startup_prescaler #(
  parameter int FAST_RISE_CK = clock_control_pkg::FAST_RISE_CYCLES,
  parameter int SLOW_RISE_CK = clock_control_pkg::SLOW_RISE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] startup_time_field,
  input wire logic clock_output_option,
  input wire logic rc_osc_selected,
  input wire logic sleep_enter,
  input wire logic [1:0] sleep_mode,
  input wire logic wake_event,
  output logic cpu_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic flash_clk_en,
  input wire logic port_pin_out,
  input wire logic port_pin_oe,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  input wire logic timer_osc_input_pin,
  output logic timer_osc_enable,
  output logic crystal_amp_enable,
  output logic timer_clock_tick,
  output logic input_buffer_disable,
  output logic startup_done
);
  import clock_control_pkg::*;

  localparam logic [BOOT_CNT_W-1:0] BOOT_BOD_LOAD =
    BOOT_CNT_W'(BOOT_BASE_CK - 1);
  localparam logic [BOOT_CNT_W-1:0] BOOT_FAST_LOAD =
    BOOT_CNT_W'(BOOT_BASE_CK + FAST_RISE_CK - 1);
  localparam logic [BOOT_CNT_W-1:0] BOOT_SLOW_LOAD =
    BOOT_CNT_W'(BOOT_BASE_CK + SLOW_RISE_CK - 1);
  localparam logic [BOOT_CNT_W-1:0] WAKE_LOAD = BOOT_CNT_W'(WAKE_CK - 1);

  function automatic logic [BOOT_CNT_W-1:0] boot_load(input logic [1:0] f);
    case (f)
      STARTUP_BOD: boot_load = BOOT_BOD_LOAD;
      STARTUP_FAST: boot_load = BOOT_FAST_LOAD;
      default: boot_load = BOOT_SLOW_LOAD;
    endcase
  endfunction : boot_load

  clk_state_type state_reg, state_next;
  logic [BOOT_CNT_W-1:0] cnt_reg, cnt_next;
  logic captured_reg;
  logic [1:0] field_reg;
  logic [1:0] mode_reg;
  logic [DIV_SEL_W-1:0] div_sel_reg;
  logic tmr_enable_reg;
  logic ext_clk_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;

  logic tick;
  logic div_clk;
  logic [DIV_SEL_W-1:0] active_sel;
  logic tmr_level;
  logic tmr_rise;

  // ---------------- bus slave ----------------
  wire access = avs_read || avs_write;
  wire hit_div = (avs_address == ADDR_DIVISION);
  wire hit_tmr = (avs_address == ADDR_TIMER_STATUS);
  wire hit_status = (avs_address == ADDR_STATUS);
  // writes commit on the edge that ends the wait state, as the host sees it
  wire wr_take = avs_write && ack_reg;
  wire lane0 = avs_byteenable[0];
  wire lane1 = avs_byteenable[1];
  // the cpu is frozen during boot, so prescaler writes are refused then
  wire div_wr_ok = wr_take && hit_div && lane0 && (state_reg != ST_BOOT) &&
    (avs_writedata[3:0] <= DIV_SEL_MAX);
  wire tmr_wr = wr_take && hit_tmr && lane0;

  wire [31:0] div_word = {28'h0, div_sel_reg};
  wire [31:0] tmr_word = {29'h0, timer_osc_enable, ext_clk_reg,
    tmr_enable_reg};
  wire [31:0] status_word = {21'h0, field_reg, input_buffer_disable,
    active_sel, 1'b0, startup_done, state_reg};
  wire [31:0] rd_word = hit_div ? div_word :
    hit_tmr ? tmr_word :
    hit_status ? status_word : 32'h0;
  wire [31:0] rd_masked = {avs_byteenable[3] ? rd_word[31:24] : 8'h0,
    avs_byteenable[2] ? rd_word[23:16] : 8'h0,
    lane1 ? rd_word[15:8] : 8'h0,
    lane0 ? rd_word[7:0] : 8'h0};

  // one wait state on every access
  assign avs_waitrequest = access && !ack_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0;
    end else begin
      ack_reg <= access && !ack_reg;
      if (avs_read && !ack_reg) begin
        readdata_reg <= rd_masked;
      end
    end
  end
  assign avs_readdata = readdata_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_sel_reg <= DIV_SEL_DEFAULT;
      tmr_enable_reg <= 1'b0;
      ext_clk_reg <= 1'b0;
    end else begin
      if (div_wr_ok) begin
        div_sel_reg <= avs_writedata[3:0];
      end
      if (tmr_wr) begin
        tmr_enable_reg <= avs_writedata[TMR_ENABLE_BIT];
        ext_clk_reg <= avs_writedata[TMR_EXT_CLK_BIT];
      end
    end
  end

  // ---------------- start-up and sleep sequencer ----------------
  wire cnt_zero = (cnt_reg == '0);
  wire deep_mode = (mode_reg == SLEEP_DEEP) || (mode_reg == 2'h3);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_BOOT: begin
        if (!captured_reg) begin
          cnt_next = boot_load(startup_time_field);
        end else if (cnt_zero) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg - BOOT_CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (sleep_enter) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          if (deep_mode) begin
            state_next = ST_WAKE;
            cnt_next = WAKE_LOAD;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_WAKE: begin
        if (cnt_zero) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg - BOOT_CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_BOOT;
      cnt_reg <= '0;
      captured_reg <= 1'b0;
      field_reg <= STARTUP_BOD;
      mode_reg <= SLEEP_IDLE;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      captured_reg <= 1'b1;
      // strap caught on the first edge after reset release
      if (!captured_reg) begin
        field_reg <= startup_time_field;
      end
      if (state_reg == ST_RUN && sleep_enter) begin
        mode_reg <= sleep_mode;
      end
    end
  end
  assign startup_done = (state_reg != ST_BOOT);

  // ---------------- prescaler and clock enables ----------------
  clock_divider #(
    .SEL_W(DIV_SEL_W),
    .CNT_W(DIV_CNT_W)
  ) u_divider (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sel_req(div_sel_reg),
    .tick(tick),
    .div_clk(div_clk),
    .active_sel(active_sel)
  );

  wire running = (state_reg == ST_RUN);
  wire sleeping = (state_reg == ST_SLEEP);
  wire io_on = running || (sleeping && mode_reg == SLEEP_IDLE);
  wire adc_on = running || (sleeping && !deep_mode);
  assign cpu_clk_en = tick && running;
  assign flash_clk_en = tick && running;
  assign io_clk_en = tick && io_on;
  assign adc_clk_en = tick && adc_on;
  assign input_buffer_disable = !io_on && !adc_on && sleeping;

  // ---------------- clock output pin ----------------
  // divide by one cannot be rebuilt from flops, so the reference itself
  // goes out; during reset the prescaler is at its divide-by-one default
  wire undivided = !nrst || (active_sel == DIV_SEL_DEFAULT);
  wire sys_clk_view = undivided ? ref_clk : div_clk;
  assign clock_output_pin = clock_output_option ? sys_clk_view :
    port_pin_out;
  assign clock_output_pin_oe = clock_output_option || port_pin_oe;

  // ---------------- timer oscillator ----------------
  assign timer_osc_enable = tmr_enable_reg && rc_osc_selected;
  assign crystal_amp_enable = timer_osc_enable && !ext_clk_reg;

  pin_synchronizer u_tmr_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in(timer_osc_input_pin),
    .level(tmr_level),
    .rise(tmr_rise)
  );
  // limitation: the timer input is only usable well below ref_clk / 4
  assign timer_clock_tick = tmr_rise && timer_osc_enable;

  // ---------------- checks ----------------
  logic [BOOT_CNT_W-1:0] elapsed_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      elapsed_reg <= '0;
    end else if (state_reg == ST_BOOT && captured_reg) begin
      elapsed_reg <= elapsed_reg + BOOT_CNT_W'(1);
    end
  end
  wire boot_leaving = (state_reg == ST_BOOT) && captured_reg && cnt_zero;

  property p_boot_bod;
    @(posedge ref_clk) disable iff (!nrst)
    (boot_leaving && field_reg == STARTUP_BOD) |->
      (elapsed_reg == BOOT_BOD_LOAD) ##1 startup_done;
  endproperty
  a_boot_bod: assert property (p_boot_bod)
    else $error("boot delay wrong for field 00");

  property p_boot_long;
    @(posedge ref_clk) disable iff (!nrst)
    (boot_leaving && field_reg != STARTUP_BOD) |->
      (elapsed_reg == boot_load(field_reg));
  endproperty
  a_boot_long: assert property (p_boot_long)
    else $error("boot delay wrong for long start-up field");

  property p_wake_len;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(state_reg == ST_WAKE) |->
      (state_reg == ST_WAKE) [*6] ##1 (state_reg == ST_RUN);
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("deep sleep wake delay is not six cycles");

  property p_clkout_drive;
    @(posedge ref_clk)
    clock_output_option |-> clock_output_pin_oe;
  endproperty
  a_clkout_drive: assert property (p_clkout_drive)
    else $error("clock output pin not driven");

  property p_clkout_divided;
    @(posedge ref_clk) disable iff (!nrst)
    (clock_output_option && active_sel != DIV_SEL_DEFAULT) |->
      (clock_output_pin == div_clk);
  endproperty
  a_clkout_divided: assert property (p_clkout_divided)
    else $error("clock output does not carry divided clock");

  property p_timer_rc_only;
    @(posedge ref_clk) disable iff (!nrst)
    !rc_osc_selected |-> !timer_osc_enable && !timer_clock_tick;
  endproperty
  a_timer_rc_only: assert property (p_timer_rc_only)
    else $error("timer oscillator active without internal rc");

  property p_ext_select;
    @(posedge ref_clk) disable iff (!nrst)
    crystal_amp_enable |-> !ext_clk_reg && tmr_enable_reg;
  endproperty
  a_ext_select: assert property (p_ext_select)
    else $error("crystal amplifier on in external clock mode");

  property p_enables_tied;
    @(posedge ref_clk) disable iff (!nrst)
    running |-> (cpu_clk_en == tick) && (io_clk_en == tick) &&
      (adc_clk_en == tick) && (flash_clk_en == tick);
  endproperty
  a_enables_tied: assert property (p_enables_tied)
    else $error("derived clock enables disagree while running");

  property p_inbuf_off;
    @(posedge ref_clk) disable iff (!nrst)
    (sleeping && deep_mode) |->
      input_buffer_disable && !io_clk_en && !adc_clk_en;
  endproperty
  a_inbuf_off: assert property (p_inbuf_off)
    else $error("input buffers enabled with io and adc stopped");

  property p_default_div;
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == ST_BOOT) |-> (div_sel_reg == DIV_SEL_DEFAULT);
  endproperty
  a_default_div: assert property (p_default_div)
    else $error("prescaler not at default during boot");
endmodule : system_clock_startup_prescaler
`default_nettype wire

// ### dv/watch_crystal_model.sv
// behavioural watch crystal or external clock on the timer oscillator pin
// assumes the bench enables it; its phase is unrelated to ref_clk
`default_nettype none
module watch_crystal_model #(
  parameter int HALF_NS = 83
) (
  input wire logic run,
  output logic osc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // fixed rate: no cycle-to-cycle drift at all, well inside the 2% limit
  initial begin
    osc_out = 1'b0;
    forever begin
      #(HALF_NS);
      // a stopped oscillator stands low rather than holding its last level
      osc_out = run ? ~osc_out : 1'b0;
    end
  end
endmodule : watch_crystal_model
`default_nettype wire

// ### dv/system_clock_startup_prescaler_bench.sv
// self-checking bench for the clock control block
// assumes the package, design files and crystal model are compiled first
`default_nettype none
module system_clock_startup_prescaler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_control_pkg::*;
  // short rise delays keep boot runs brief
  localparam int FAST = 20;
  localparam int SLOW = 40;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] startup_time_field = 2'h0;
  logic [1:0] sleep_mode = 2'h0;
  logic clock_output_option = 1'b0;
  logic rc_osc_selected = 1'b0;
  logic sleep_enter = 1'b0;
  logic wake_event = 1'b0;
  logic port_pin_out = 1'b0;
  logic port_pin_oe = 1'b0;
  logic osc_run = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cpu_clk_en, io_clk_en, adc_clk_en, flash_clk_en;
  logic clock_output_pin, clock_output_pin_oe, timer_osc_input_pin;
  logic timer_osc_enable, crystal_amp_enable, timer_clock_tick;
  logic input_buffer_disable, startup_done;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 5;
  int cnt [7];
  int nxt, lo, n;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];

  system_clock_startup_prescaler #(
    .FAST_RISE_CK(FAST),
    .SLOW_RISE_CK(SLOW)
  ) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .startup_time_field(startup_time_field),
    .clock_output_option(clock_output_option),
    .rc_osc_selected(rc_osc_selected), .sleep_enter(sleep_enter),
    .sleep_mode(sleep_mode), .wake_event(wake_event),
    .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
    .adc_clk_en(adc_clk_en), .flash_clk_en(flash_clk_en),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .clock_output_pin(clock_output_pin),
    .clock_output_pin_oe(clock_output_pin_oe),
    .timer_osc_input_pin(timer_osc_input_pin),
    .timer_osc_enable(timer_osc_enable),
    .crystal_amp_enable(crystal_amp_enable),
    .timer_clock_tick(timer_clock_tick),
    .input_buffer_disable(input_buffer_disable),
    .startup_done(startup_done)
  );

  watch_crystal_model i_xtal (.run(osc_run), .osc_out(timer_osc_input_pin));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s: got %0h, expected %0h", $time, what,
               got, exp);
    end
  endtask : check

  // read data is compared by the watcher once the slave answers
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     input logic [31:0] e, input logic [31:0] m);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50) begin
      mismatches++;
      $display("MISMATCH t=%0t bus answer never came", $time);
      close_out();
    end
  endtask : bus

  // sampled at the edge that ends the wait state, before anything moves
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected read");
      else check(avs_readdata & msk_q.pop_front(), exp_q.pop_front(),
                 "read data");
    end
  end

  task automatic do_reset(input logic [1:0] f, input logic opt);
    @(posedge ref_clk);
    nrst <= 1'b0;
    startup_time_field <= f;
    clock_output_option <= opt;
    repeat (2) @(posedge ref_clk);
    #2;
    check({clock_output_pin, clock_output_pin_oe},
          opt ? 2'h3 : {port_pin_out, port_pin_oe}, "pin in reset");
    @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic count_boot(input int e);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (startup_done !== 1'b1 && k < 200);
    check(k, e, "boot length");
  endtask : count_boot

  task automatic tally(input int win);
    cnt = '{default: 0};
    repeat (win) begin
      @(posedge ref_clk);
      #1;
      cnt[0] += (cpu_clk_en === 1'b1);
      cnt[1] += (io_clk_en === 1'b1);
      cnt[2] += (adc_clk_en === 1'b1);
      cnt[3] += (flash_clk_en === 1'b1);
      cnt[4] += (clock_output_pin === 1'b1);
      cnt[5] += (timer_clock_tick === 1'b1);
      cnt[6] += (input_buffer_disable === 1'b1);
    end
  endtask : tally

  // no tick gap or high phase shorter than the faster setting allows
  task automatic watch(input int l, input int win);
    int gap, run;
    bit seen, hseen;
    gap = 0;
    run = 0;
    seen = 0;
    hseen = 0;
    repeat (win) begin
      @(posedge ref_clk);
      #1;
      gap++;
      if (cpu_clk_en === 1'b1) begin
        if (seen) check(gap >= (1 << l), 1, "short tick gap");
        seen = 1;
        gap = 0;
      end
      if (clock_output_pin === 1'b1) run++;
      else begin
        if (run > 0 && hseen && l > 0)
          check(run >= (1 << (l - 1)), 1, "runt high phase");
        if (run > 0) hseen = 1;
        run = 0;
      end
    end
  endtask : watch

  initial begin
    do_reset(STARTUP_BOD, 1'b0);
    count_boot(15);
    repeat (8) begin
      @(posedge ref_clk);
      {port_pin_out, port_pin_oe} <= 2'($random(seed));
      @(negedge ref_clk);
      check({clock_output_pin, clock_output_pin_oe},
            {port_pin_out, port_pin_oe}, "port use");
    end
    do_reset(STARTUP_FAST, 1'b1);
    count_boot(15 + FAST);
    do_reset(STARTUP_SLOW, 1'b1);
    fork
      count_boot(15 + SLOW);
      bus(1'b1, ADDR_DIVISION, 32'h2, 4'hf, 0, 0);
    join
    bus(1'b0, ADDR_DIVISION, 0, 4'hf, 32'h0, 32'hf);
    bus(1'b0, ADDR_STATUS, 0, 4'hf, 32'h405, 32'h7ff);
    bus(1'b1, ADDR_DIVISION, 32'h9, 4'hf, 0, 0);
    bus(1'b1, ADDR_DIVISION, 32'h3, 4'he, 0, 0);
    bus(1'b1, 4'hc, 32'h5, 4'hf, 0, 0);
    bus(1'b0, 4'hc, 0, 4'hf, 32'h0, 32'hffffffff);
    bus(1'b0, ADDR_DIVISION, 0, 4'hf, 32'h0, 32'hf);
    $display("test done: boot and registers");
    for (int i = 0; i < 8; i++) begin
      // last pass ends at divide by one, which the sleep counts rely on
      nxt = (i == 0) ? 8 : (i == 1 || i == 7) ? 0 : {$random(seed)} % 9;
      lo = (nxt < n) ? nxt : n;
      fork
        watch(lo, 640);
        bus(1'b1, ADDR_DIVISION, 32'(nxt), 4'hf, 0, 0);
      join
      bus(1'b0, ADDR_STATUS, 0, 4'hf, 32'(nxt) << 4, 32'hf0);
      tally(256);
      for (int j = 0; j < 4; j++) check(cnt[j], 256 >> nxt, "ticks");
      check(cnt[4], (nxt == 0) ? 256 : 128, "pin high count");
      n = nxt;
    end
    $display("test done: prescaler");
    for (int m = 0; m < 3; m++) begin
      @(posedge ref_clk);
      sleep_mode <= 2'(m);
      sleep_enter <= 1'b1;
      @(posedge ref_clk);
      sleep_enter <= 1'b0;
      tally(32);
      check(cnt[0] + cnt[3], 0, "cpu and flash in sleep");
      check(cnt[1], (m == 0) ? 32 : 0, "io in sleep");
      check(cnt[2], (m < 2) ? 32 : 0, "adc in sleep");
      check(cnt[6], (m == 2) ? 32 : 0, "buffers off");
      @(posedge ref_clk);
      wake_event <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        wake_event <= 1'b0;
        #1;
        n++;
      end while (cpu_clk_en !== 1'b1 && n < 20);
      check(n, (m == 2) ? 7 : 1, "wake time");
    end
    $display("test done: sleep");
    @(posedge ref_clk);
    rc_osc_selected <= 1'b1;
    osc_run <= 1'b1;
    for (int x = 1; x < 4; x += 2) begin
      bus(1'b1, ADDR_TIMER_STATUS, 32'(x), 4'hf, 0, 0);
      tally(160);
      check({timer_osc_enable, crystal_amp_enable}, {1'b1, x == 1},
            "osc enables");
      check(cnt[5] inside {[8:11]}, 1, "timer ticks");
    end
    bus(1'b1, ADDR_TIMER_STATUS, 32'h0, 4'he, 0, 0);
    bus(1'b0, ADDR_TIMER_STATUS, 0, 4'hf, 32'h3, 32'h3);
    rc_osc_selected <= 1'b0;
    repeat (8) @(posedge ref_clk);
    tally(160);
    check({timer_osc_enable, cnt[5] == 0}, 2'h1, "osc without rc");
    osc_run <= 1'b0;
    $display("test done: timer oscillator");
    close_out();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("MISMATCH t=%0t run too long", $time);
    close_out();
  end
endmodule : system_clock_startup_prescaler_bench
`default_nettype wire
